// [cpg_controller.sv]
`timescale 1ns/1ns
module cpg_controller (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // enable pin, asynchronous
  input wire logic enable_n,
  // register contents
  input wire logic [7:0] mode_control_register,
  input wire logic [7:0] output_ceiling_register,
  input wire logic [7:0] torch_current_register,
  input wire logic [7:0] flash_current_register,
  // analog comparators, asynchronous
  input wire cpg_pkg::cpg_cmp_t cmp,
  input wire cpg_pkg::cpg_chan_t chan,
  // power stage
  output cpg_pkg::cpg_drive_t drive,
  // status
  output logic standby,
  output logic thermal_off,
  output logic auto_active
);
  // synchronisers
  localparam int unsigned SYN_W = $bits(cpg_pkg::cpg_cmp_t) + $bits(cpg_pkg::cpg_chan_t) + 1;
  logic [SYN_W-1:0] syn1_r;
  logic [SYN_W-1:0] syn2_r;
  cpg_pkg::cpg_cmp_t c;
  cpg_pkg::cpg_chan_t ch;
  logic en_n_s;
  localparam logic [SYN_W-1:0] SYN_RST = {1'b1, {(SYN_W-1){1'b0}}};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      // enable reads as off until real pin levels have passed both flops
      syn1_r <= SYN_RST;
      syn2_r <= SYN_RST;
    end else begin
      syn1_r <= {enable_n, cmp, chan};
      syn2_r <= syn1_r;
    end
  end
  assign {en_n_s, c, ch} = syn2_r;

  // mode decode
  cpg_pkg::cpg_op_t op;
  logic [1:0] gain_field;
  cpg_mode_decode u_dec (
    .mode_control_register(mode_control_register),
    .op(op),
    .gain_field(gain_field)
  );

  logic is_auto;
  logic is_he;
  logic active;
  logic [cpg_pkg::NUM_CH-1:0] ch_req;
  assign is_auto = (op == cpg_pkg::CPG_OP_AUTO_TORCH) || (op == cpg_pkg::CPG_OP_AUTO_FLASH);
  assign is_he = (op == cpg_pkg::CPG_OP_HE_TORCH);
  assign ch_req = torch_current_register[cpg_pkg::CH_EN_HI:cpg_pkg::CH_EN_LO]
                | flash_current_register[cpg_pkg::CH_EN_HI:cpg_pkg::CH_EN_LO];
  assign standby = (ch_req == cpg_pkg::CH_RST);

  // thermal hysteresis
  logic thermal_r;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      thermal_r <= 1'b0;
    end else if (c.over_temp_150) begin
      thermal_r <= 1'b1;
    end else if (c.under_temp_140) begin
      thermal_r <= 1'b0;
    end
  end
  assign thermal_off = thermal_r;
  assign active = !en_n_s && !thermal_r && (op != cpg_pkg::CPG_OP_OFF);

  // pump clock enable divider
  logic [3:0] div_r;
  logic pump_tick;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_r <= '0;
    end else if (div_r == cpg_pkg::PUMP_DIV_LAST) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end
  assign pump_tick = (div_r == cpg_pkg::PUMP_DIV_LAST);

  // auto start sequencing
  typedef enum logic [2:0] {
    AS_IDLE = 3'b001,
    AS_CHARGE = 3'b010,
    AS_DONE = 3'b100
  } cpg_as_t;
  cpg_as_t as_r;
  cpg_pkg::cpg_op_t op_last_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      as_r <= AS_IDLE;
      op_last_r <= cpg_pkg::CPG_OP_OFF;
    end else if (!active || !is_auto) begin
      as_r <= AS_IDLE;
      op_last_r <= op;
    end else begin
      op_last_r <= op;
      unique case (as_r)
        AS_IDLE: begin
          as_r <= c.vout_at_ceiling ? AS_DONE : AS_CHARGE;
        end
        AS_CHARGE: begin
          if (c.vout_at_ceiling) begin
            as_r <= AS_DONE;
          end
        end
        AS_DONE: begin
          if (op != op_last_r) begin
            as_r <= AS_IDLE;
          end
        end
      endcase
    end
  end
  assign auto_active = (as_r != AS_DONE) && active && is_auto;

  // gain state
  cpg_pkg::cpg_gain_t gain_r;
  cpg_pkg::cpg_gain_t gain_nxt;
  cpg_pkg::cpg_gain_t gain_max;
  logic [6:0] step_r;
  logic he_dropout;
  logic he_run_r;

  // adaptive dropout threshold per gain
  assign he_dropout = (gain_r == cpg_pkg::CPG_G1X) ? (|ch.below_220)
                                                   : (|ch.below_180);

  always_comb begin
    unique case (gain_field)
      2'h1: gain_max = cpg_pkg::CPG_G1X;
      2'h2: gain_max = cpg_pkg::CPG_G15X;
      default: gain_max = cpg_pkg::CPG_G2X;
    endcase
  end

  always_comb begin
    gain_nxt = gain_r;
    if (auto_active) begin
      if (as_r == AS_IDLE) begin
        gain_nxt = c.vout_above_vin ? cpg_pkg::CPG_G15X : cpg_pkg::CPG_G1X;
      end else if (gain_r == cpg_pkg::CPG_G1X && c.iin_below_400) begin
        gain_nxt = cpg_pkg::CPG_G15X;
      end else if (gain_r == cpg_pkg::CPG_G15X && c.iin_below_300 && !c.vout_at_ceiling) begin
        gain_nxt = cpg_pkg::CPG_G2X;
      end
    end else if (is_he) begin
      if (he_run_r && he_dropout && pump_tick && step_r == cpg_pkg::STEP_LAST
          && gain_r != cpg_pkg::CPG_G2X) begin
        gain_nxt = cpg_cpg_inc(gain_r);
      end
    end else if (op == cpg_pkg::CPG_OP_PROG) begin
      gain_nxt = gain_max;
    end
  end

  function automatic cpg_pkg::cpg_gain_t cpg_cpg_inc(input cpg_pkg::cpg_gain_t g);
    cpg_cpg_inc = (g == cpg_pkg::CPG_G1X) ? cpg_pkg::CPG_G15X : cpg_pkg::CPG_G2X;
  endfunction : cpg_cpg_inc

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gain_r <= cpg_pkg::CPG_G1X;
    end else if (!active) begin
      gain_r <= cpg_pkg::CPG_G1X;
    end else begin
      gain_r <= gain_nxt;
    end
  end

  // high-efficiency torch loop
  logic he_charged_r;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      he_charged_r <= 1'b0;
      he_run_r <= 1'b0;
    end else if (!active || !is_he) begin
      he_charged_r <= 1'b0;
      he_run_r <= 1'b0;
    end else if (c.vout_at_ceiling) begin
      he_charged_r <= 1'b1;
      he_run_r <= 1'b0;
    end else if (he_charged_r && he_dropout && !standby) begin
      he_run_r <= 1'b1;
    end else if (he_charged_r && !he_dropout) begin
      he_run_r <= 1'b0;
    end
  end

  // 64 pump-cycle gain step timer, restarted at each pump start
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      step_r <= '0;
    end else if (!he_run_r) begin
      step_r <= '0;
    end else if (pump_tick) begin
      step_r <= (step_r == cpg_pkg::STEP_LAST) ? 7'h00 : step_r + 7'h01;
    end
  end

  // gain limits from output versus input
  cpg_pkg::cpg_gain_t gain_lim;
  always_comb begin
    gain_lim = gain_r;
    if (c.out_short || c.vout_below_vin_m1) begin
      gain_lim = cpg_pkg::CPG_G1X;
    end else if (!c.vout_above_vin && gain_r == cpg_pkg::CPG_G2X) begin
      gain_lim = cpg_pkg::CPG_G15X;
    end else if (c.vout_above_vin && gain_r == cpg_pkg::CPG_G1X) begin
      gain_lim = cpg_pkg::CPG_G15X;
    end
  end

  // output drive, registered
  logic pump_want;
  assign pump_want = active && !c.vout_at_ceiling && !c.vout_open
                   && (auto_active || (is_he && (!he_charged_r || he_run_r))
                       || (!is_he && !is_auto));

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      drive <= '0;
    end else begin
      drive.pump_on <= pump_want;
      drive.gain <= active ? gain_lim : cpg_pkg::CPG_G1X;
      drive.ilim_600 <= 1'b1;
      drive.disconnect <= !active || c.vout_open;
      drive.torch_ceiling <= is_he || (op == cpg_pkg::CPG_OP_AUTO_TORCH);
      drive.ch_on <= (active && !auto_active) ? (ch_req & ~ch.led_short)
                                              : cpg_pkg::CH_RST;
    end
  end

  // checks
  AST_HE_CODE: assert property (@(posedge core_clk) disable iff (!arst_n)
    is_he |-> (mode_control_register[7:3] ==? 5'b01?00))
    else $error("he torch on wrong code");
  AST_AUTO_LEDS_OFF: assert property (@(posedge core_clk) disable iff (!arst_n)
    auto_active |=> drive.ch_on == '0)
    else $error("leds on during auto start");
  AST_CEIL_STOP: assert property (@(posedge core_clk) disable iff (!arst_n)
    c.vout_at_ceiling |=> !drive.pump_on)
    else $error("pump on at ceiling");
  AST_AUTO_DONE: assert property (@(posedge core_clk) disable iff (!arst_n)
    (auto_active && c.vout_at_ceiling) |=> !auto_active)
    else $error("auto start still running after ceiling");
  AST_START_GAIN: assert property (@(posedge core_clk) disable iff (!arst_n)
    (auto_active && as_r == AS_IDLE && !c.vout_above_vin) |=> gain_r == cpg_pkg::CPG_G1X)
    else $error("auto start gain wrong");
  sequence s_he_stall;
    he_run_r && he_dropout && pump_tick && step_r == cpg_pkg::STEP_LAST
      && gain_r == cpg_pkg::CPG_G1X && is_he && active;
  endsequence
  AST_STEP: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_he_stall |=> gain_r == cpg_pkg::CPG_G15X)
    else $error("gain step missed");
  // torch loop armed: charged once, output now under the ceiling
  sequence s_he_armed;
    is_he && active && he_charged_r && !c.vout_at_ceiling;
  endsequence
  AST_HE_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n)
    (s_he_armed ##0 !he_run_r) |=> !drive.pump_on)
    else $error("torch pump on without dropout");
  AST_HE_START: assert property (@(posedge core_clk) disable iff (!arst_n)
    (s_he_armed ##0 (he_dropout && !standby)) |=> he_run_r)
    else $error("torch pump not started on dropout");
  AST_THERM: assert property (@(posedge core_clk) disable iff (!arst_n)
    thermal_r |=> drive.ch_on == '0 && !drive.pump_on)
    else $error("running while hot");
  AST_THERM_SET: assert property (@(posedge core_clk) disable iff (!arst_n)
    c.over_temp_150 |=> thermal_r)
    else $error("over temperature not latched");
  AST_THERM_CLR: assert property (@(posedge core_clk) disable iff (!arst_n)
    (thermal_r && !c.over_temp_150 && c.under_temp_140) |=> !thermal_r)
    else $error("thermal latch not released");
  AST_SHORT: assert property (@(posedge core_clk) disable iff (!arst_n)
    c.out_short |=> drive.gain == cpg_pkg::CPG_G1X && drive.ilim_600)
    else $error("short not 1x");
  AST_LED_SHORT: assert property (@(posedge core_clk) disable iff (!arst_n)
    ##1 ($past(ch.led_short) & drive.ch_on) == '0)
    else $error("shorted channel driven");
  AST_OPEN: assert property (@(posedge core_clk) disable iff (!arst_n)
    c.vout_open |=> drive.disconnect && !drive.pump_on)
    else $error("open sense not disconnected");
  AST_LOW_VOUT: assert property (@(posedge core_clk) disable iff (!arst_n)
    c.vout_below_vin_m1 |=> drive.gain == cpg_pkg::CPG_G1X)
    else $error("gain above 1x at low vout");
  AST_MID_VOUT: assert property (@(posedge core_clk) disable iff (!arst_n)
    (active && !c.vout_above_vin && !c.vout_below_vin_m1)
      |=> drive.gain != cpg_pkg::CPG_G2X)
    else $error("2x while vout below vin");
  AST_HIGH_VOUT: assert property (@(posedge core_clk) disable iff (!arst_n)
    (active && c.vout_above_vin && !c.vout_below_vin_m1 && !c.out_short)
      |=> drive.gain != cpg_pkg::CPG_G1X)
    else $error("1x while vout above vin");
  AST_TORCH_CEIL: assert property (@(posedge core_clk) disable iff (!arst_n)
    (is_he || op == cpg_pkg::CPG_OP_AUTO_TORCH) |=> drive.torch_ceiling)
    else $error("torch ceiling not selected");
  AST_STANDBY: assert property (@(posedge core_clk) disable iff (!arst_n)
    standby |=> drive.ch_on == '0)
    else $error("channel on in standby");
  AST_RETURN_START: assert property (@(posedge core_clk) disable iff (!arst_n)
    (active && op == cpg_pkg::CPG_OP_PROG && gain_field == cpg_pkg::GAIN_FIELD_1X5
      && output_ceiling_register[7:5] == cpg_pkg::CEIL_CODE_MAX
      && !c.vout_at_ceiling && !c.vout_open) |=> drive.pump_on)
    else $error("forced 1.5x did not restart the pump");
  AST_EN_OFF: assert property (@(posedge core_clk) disable iff (!arst_n)
    en_n_s |=> !drive.pump_on && drive.ch_on == '0)
    else $error("active while disabled");
endmodule : cpg_controller

// [cpg_mode_decode.sv]
`timescale 1ns/1ns
module cpg_mode_decode (
  // mode control register
  input wire logic [7:0] mode_control_register,
  // decoded operation
  output cpg_pkg::cpg_op_t op,
  output logic [1:0] gain_field
);
  logic [3:0] sel;

  assign sel = {mode_control_register[cpg_pkg::MODE_B7_POS],
                mode_control_register[cpg_pkg::MODE_B6_POS],
                mode_control_register[cpg_pkg::MODE_B4_POS],
                mode_control_register[cpg_pkg::MODE_B3_POS]};
  assign gain_field = sel[1:0];

  always_comb begin
    if (sel == 4'h4) begin
      op = cpg_pkg::CPG_OP_HE_TORCH;
    end else if (sel == 4'h8) begin
      op = cpg_pkg::CPG_OP_AUTO_TORCH;
    end else if (sel == 4'hc) begin
      op = cpg_pkg::CPG_OP_AUTO_FLASH;
    end else if (sel[3:2] != 2'h0) begin
      op = cpg_pkg::CPG_OP_PROG;
    end else begin
      op = cpg_pkg::CPG_OP_OFF;
    end
  end
endmodule : cpg_mode_decode

// [cpg_pkg.sv]
package cpg_pkg;
  // mode control register bit positions
  localparam int unsigned MODE_B7_POS = 7;
  localparam int unsigned MODE_B6_POS = 6;
  localparam int unsigned MODE_B4_POS = 4;
  localparam int unsigned MODE_B3_POS = 3;
  // gain field (B4..B3) of the mode control register
  localparam logic [1:0] GAIN_FIELD_AUTO = 2'h0;
  localparam logic [1:0] GAIN_FIELD_1X5 = 2'h2;
  // ceiling codes (output ceiling register B7..B5)
  localparam logic [2:0] CEIL_CODE_RETURN = 3'h6;
  localparam logic [2:0] CEIL_CODE_MAX = 3'h7;
  // channel enable bits B7..B5 of the current registers
  localparam int unsigned CH_EN_HI = 7;
  localparam int unsigned CH_EN_LO = 5;
  localparam int unsigned NUM_CH = 3;
  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [2:0] CH_RST = 3'h0;
  // timing: gain step after 64 pump clock cycles at 2.4 MHz; the 4-cycle divider ticks at 2.5 MHz
  localparam int unsigned CORE_CLK_HZ = 10000000;
  localparam int unsigned PUMP_CLK_HZ = 2400000;
  localparam int unsigned STEP_PUMP_CYCLES = 64;
  // pump clock enable divider: whole core cycles per pump tick
  localparam int unsigned PUMP_DIV = CORE_CLK_HZ / PUMP_CLK_HZ;
  localparam logic [3:0] PUMP_DIV_LAST = 4'(PUMP_DIV - 1);
  localparam logic [6:0] STEP_LAST = 7'(STEP_PUMP_CYCLES - 1);

  typedef enum logic [1:0] {
    CPG_G1X = 2'h0,
    CPG_G15X = 2'h1,
    CPG_G2X = 2'h2
  } cpg_gain_t;

  typedef enum logic [2:0] {
    CPG_OP_OFF = 3'h0,
    CPG_OP_HE_TORCH = 3'h1,
    CPG_OP_AUTO_TORCH = 3'h2,
    CPG_OP_AUTO_FLASH = 3'h3,
    CPG_OP_PROG = 3'h4
  } cpg_op_t;

  // analog comparator results
  typedef struct packed {
    logic vout_at_ceiling;
    logic vout_above_vin;
    logic vout_below_vin_m1;
    logic iin_below_400;
    logic iin_below_300;
    logic over_temp_150;
    logic under_temp_140;
    logic out_short;
    logic vout_open;
  } cpg_cmp_t;

  // per-channel comparator results
  typedef struct packed {
    logic [NUM_CH-1:0] below_220;
    logic [NUM_CH-1:0] below_180;
    logic [NUM_CH-1:0] led_short;
  } cpg_chan_t;

  // drive to the power stage
  typedef struct packed {
    logic pump_on;
    cpg_gain_t gain;
    logic ilim_600;
    logic disconnect;
    logic torch_ceiling;
    logic [NUM_CH-1:0] ch_on;
  } cpg_drive_t;
endpackage : cpg_pkg

// [cpg_stage_model.sv]
`timescale 1ns/1ns
module cpg_stage_model (
  // clock
  input wire logic core_clk,
  // drive from the controller and ceiling code
  input wire cpg_pkg::cpg_drive_t drive,
  input wire logic [2:0] ceil_code,
  // comparators not tied to the output voltage
  input wire cpg_pkg::cpg_cmp_t cmp_ext,
  output cpg_pkg::cpg_cmp_t cmp
);
  int vout_mv = 0;
  int vin_mv = 3600;
  // charge added per cycle while pumping; zero freezes the output
  int step_mv = 0;
  int lim_mv;
  always_comb begin
    if (drive.torch_ceiling) lim_mv = 4500;
    else lim_mv = (ceil_code == 3'h7) ? 5600 : ((ceil_code == 3'h6) ? 5450 : 5000);
  end
  // a disconnected output gets no charge; an open output only once drive.disconnect is set
  always @(posedge core_clk) begin
    if (drive.pump_on && !drive.disconnect && vout_mv < lim_mv) vout_mv <= vout_mv + step_mv;
  end
  always_comb begin
    cmp = cmp_ext;
    cmp.vout_at_ceiling = vout_mv >= lim_mv;
    cmp.vout_above_vin = vout_mv > vin_mv;
    cmp.vout_below_vin_m1 = vout_mv < vin_mv - 1000;
  end
endmodule : cpg_stage_model

// [testbench.sv]
`timescale 1ns/1ns
module testbench;
  localparam cpg_pkg::cpg_gain_t G1 = cpg_pkg::CPG_G1X;
  localparam cpg_pkg::cpg_gain_t G15 = cpg_pkg::CPG_G15X;
  localparam cpg_pkg::cpg_gain_t G2 = cpg_pkg::CPG_G2X;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic enable_n = 1'b1;
  logic [7:0] mcr = 8'h00;
  logic [7:0] ocr = 8'h00;
  logic [7:0] tcr = 8'h00;
  logic [7:0] fcr = 8'h00;
  cpg_pkg::cpg_cmp_t cmp_ext = '0;
  cpg_pkg::cpg_cmp_t cmp;
  cpg_pkg::cpg_chan_t chan = '0;
  cpg_pkg::cpg_drive_t drive;
  logic standby;
  logic thermal_off;
  logic auto_active;
  int error_cnt = 0;
  int compares = 0;
  int vi;
  int vo;
  logic [2:0] en;
  logic [2:0] sh;

  always #50 core_clk = ~core_clk;

  cpg_controller dut (.core_clk(core_clk), .arst_n(arst_n), .enable_n(enable_n),
    .mode_control_register(mcr), .output_ceiling_register(ocr),
    .torch_current_register(tcr), .flash_current_register(fcr), .cmp(cmp), .chan(chan),
    .drive(drive), .standby(standby), .thermal_off(thermal_off), .auto_active(auto_active));
  cpg_stage_model pm (.core_clk(core_clk), .drive(drive), .ceil_code(ocr[7:5]),
    .cmp_ext(cmp_ext), .cmp(cmp));

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      error_cnt++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  // expected first gain of auto start
  function automatic cpg_pkg::cpg_gain_t start_gain(input int o, input int i);
    return (o > i) ? G15 : G1;
  endfunction : start_gain

  task automatic volt(input int o, input int i);
    pm.vout_mv = o;
    pm.vin_mv = i;
  endtask : volt

  // outputs trail comparator and enable inputs by two sync flops plus one register
  task automatic mode(input logic [7:0] m);
    mcr = 8'h00;
    cyc(4);
    mcr = m;
    cyc(4);
  endtask : mode

  task automatic wait_gain(input cpg_pkg::cpg_gain_t g, input int lim);
    for (int i = 0; i < lim && drive.gain !== g; i++) cyc(1);
  endtask : wait_gain

  task automatic wait_stop();
    for (int i = 0; i < 300 && drive.pump_on !== 1'b0; i++) cyc(1);
    cyc(4);
  endtask : wait_stop

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'hd4e33a83));
    volt(1000, 3600);
    cyc(16);
    chk(drive, 16'h0000);
    arst_n = 1'b1;
    mcr = 8'h40;
    tcr = 8'he0;
    chan.below_220 = 3'h7;
    cyc(4);
    chk({drive.pump_on, drive.ch_on}, 16'h0000);
    chan = '0;
    enable_n = 1'b0;
    repeat (6) begin
      vi = 2700 + $urandom_range(1000);
      vo = vi - 900 + $urandom_range(1300);
      en = 3'($urandom_range(1, 7));
      tcr = {en, 5'h00};
      pm.step_mv = 0;
      volt(vo, vi);
      mode($urandom_range(1) ? 8'hc0 : 8'h80);
      chk({auto_active, drive.pump_on, drive.ch_on}, 16'h0018);
      chk(drive.gain, start_gain(vo, vi));
      chk(drive.torch_ceiling, !mcr[6]);
      cmp_ext.iin_below_400 = 1'b1;
      wait_gain(G15, 300);
      chk(drive.gain, G15);
      volt(vi + 100, vi);
      cmp_ext.iin_below_300 = 1'b1;
      wait_gain(G2, 300);
      cyc(40);
      chk({drive.pump_on, drive.gain}, {1'b1, G2});
      pm.step_mv = 40;
      wait_stop();
      chk({auto_active, drive.pump_on, drive.ch_on}, {2'b00, en});
      cmp_ext = '0;
    end
    // host pulls the enable pin to stop a pump stuck in 2x
    pm.step_mv = 0;
    volt(3700, 3600);
    cmp_ext.iin_below_400 = 1'b1;
    cmp_ext.iin_below_300 = 1'b1;
    mode(8'h80);
    wait_gain(G2, 300);
    chk({drive.pump_on, drive.gain}, {1'b1, G2});
    enable_n = 1'b1;
    cyc(4);
    chk({drive.pump_on, drive.ch_on, drive.disconnect}, 16'h0001);
    enable_n = 1'b0;
    cmp_ext = '0;
    tcr = 8'he0;
    volt(4000, 4600);
    mode(8'h40);
    chk({drive.pump_on, drive.torch_ceiling}, 16'h0003);
    volt(4500, 4600);
    cyc(4);
    chk(drive.pump_on, 1'b0);
    volt(4400, 4600);
    cyc(4);
    chk({drive.pump_on, drive.ch_on}, 16'h0007);
    chan.below_220 = 3'h2;
    chan.below_180 = 3'h2;
    cyc(4);
    chk({drive.pump_on, drive.gain}, {1'b1, G1});
    cyc(200);
    chk(drive.gain, G1);
    wait_gain(G15, 100);
    chk(drive.gain, G15);
    chan.below_180 = 3'h0;
    cyc(400);
    chk(drive.gain, G15);
    volt(4500, 4600);
    cyc(4);
    chk(drive.pump_on, 1'b0);
    chan = '0;
    sh = 3'($urandom_range(1, 6));
    chan.led_short = sh;
    cyc(4);
    chk(drive.ch_on, 3'h7 & ~sh);
    chan = '0;
    volt(4000, 4600);
    cmp_ext.out_short = 1'b1;
    cyc(4);
    chk({drive.gain, drive.ilim_600}, {G1, 1'b1});
    cmp_ext = '0;
    cmp_ext.vout_open = 1'b1;
    cyc(4);
    chk(drive.disconnect, 1'b1);
    cmp_ext = '0;
    chan.below_220 = 3'h7;
    chan.below_180 = 3'h7;
    cmp_ext.over_temp_150 = 1'b1;
    cyc(4);
    chk({thermal_off, drive.pump_on, drive.ch_on}, 16'h0010);
    cmp_ext.over_temp_150 = 1'b0;
    cyc(4);
    chk(thermal_off, 1'b1);
    cmp_ext.under_temp_140 = 1'b1;
    cyc(4);
    chk(thermal_off, 1'b0);
    cmp_ext = '0;
    chan = '0;
    volt(2000, 3600);
    mode(8'h98);
    chk(drive.gain, G1);
    volt(3300, 3600);
    cyc(4);
    chk(drive.gain, G15);
    volt(4000, 3600);
    cyc(4);
    chk(drive.gain, G2);
    tcr = 8'h00;
    fcr = 8'he0;
    ocr = 8'hc0;
    volt(5000, 3000);
    pm.step_mv = 40;
    mode(8'hc0);
    wait_stop();
    chk(drive.pump_on, 1'b0);
    pm.step_mv = 0;
    mcr = 8'hd0;
    ocr = 8'he0;
    cyc(4);
    chk({drive.pump_on, drive.gain}, {1'b1, G15});
    // reset in mid-run clears the drive, then the same mode resumes
    arst_n = 1'b0;
    cyc(1);
    chk(drive, 16'h0000);
    arst_n = 1'b1;
    cyc(4);
    chk({drive.pump_on, drive.gain}, {1'b1, G15});
    fcr = 8'h00;
    cyc(4);
    chk(standby, 1'b1);
    tcr = 8'h20;
    cyc(4);
    chk(standby, 1'b0);
    tally_and_finish();
  end
endmodule : testbench
